// *** src/srso_map.svh ***
// named offsets, field positions, reset values and fixed figures
// assumes it is included by bare name from the design and bench files
`ifndef SRSO_MAP_SVH
`define SRSO_MAP_SVH

// ****************************************************************
// register byte addresses on the avalon slave
// ****************************************************************
`define SRSO_ADDR_CTRL     5'h00
`define SRSO_ADDR_OPERAND  5'h04
`define SRSO_ADDR_STATUS   5'h08
`define SRSO_ADDR_PC       5'h0C
`define SRSO_ADDR_SP       5'h10
`define SRSO_ADDR_BUSY     5'h14

// ****************************************************************
// field positions
// ****************************************************************
`define SRSO_CTRL_OP_LSB   0
`define SRSO_CTRL_OP_MSB   2
`define SRSO_CTRL_BYTE     4
`define SRSO_SW_C          0
`define SRSO_SW_Z          1
`define SRSO_SW_N          2
`define SRSO_SW_V          8
`define SRSO_SW_PCHI_LSB   12
`define SRSO_SW_PCHI_MSB   15

// ****************************************************************
// reset values and fixed figures
// ****************************************************************
`define SRSO_RST_SW        16'h0000
`define SRSO_RST_PC        20'h00000
`define SRSO_RST_SP        20'h00000
`define SRSO_RST_WORD      16'h0000
`define SRSO_STACK_STEP    20'h00002
`define SRSO_PCHI_CLEAR    4'h0
`define SRSO_BE_WORD       2'h3
`define SRSO_BE_LOW        2'h1
`define SRSO_SHL_V_LO_W    16'h4000
`define SRSO_SHL_V_HI_W    16'hC000
`define SRSO_SHL_V_LO_B    16'h0040
`define SRSO_SHL_V_HI_B    16'h00C0
`define SRSO_SBC_ADD_W     17'h0FFFF
`define SRSO_SBC_ADD_B     17'h000FF
`define SRSO_BYTE_MASK     16'h00FF

`endif

// *** src/srso_pkg.sv ***
// types shared by the stack, return and shift datapath
// uses nothing from srso_map.svh; it holds only the two enums
package srso_pkg;

  // ****************************************************************
  // operation codes as written to the control register
  // ****************************************************************
  typedef enum logic [2:0]
  {
    SRSO_OP_PUSH   = 3'b000,
    SRSO_OP_SUBEX  = 3'b001,
    SRSO_OP_INTEX  = 3'b010,
    SRSO_OP_SHL    = 3'b011,
    SRSO_OP_ROTL   = 3'b100,
    SRSO_OP_SHR    = 3'b101,
    SRSO_OP_ROTR   = 3'b110,
    SRSO_OP_SBC    = 3'b111
  } srso_op_t;

  // ****************************************************************
  // sequencer states
  // ****************************************************************
  typedef enum logic [2:0]
  {
    SRSO_ST_IDLE   = 3'b000,
    SRSO_ST_PUSH   = 3'b001,
    SRSO_ST_SUBEX  = 3'b010,
    SRSO_ST_INT_SW = 3'b011,
    SRSO_ST_INT_PC = 3'b100
  } srso_state_t;

endpackage

// *** src/srso_alu.sv ***
// single-step shift, rotate and subtract-borrow datapath
// assumes the caller holds operand, carry and size stable for the cycle
`timescale 1ns/1ps
`default_nettype none
`include "srso_map.svh"

module srso_alu
(
  input  wire logic             byte_mode,
  input  wire srso_pkg::srso_op_t op,
  input  wire logic [15:0]      dst,
  input  wire logic             carry_in,
  output logic      [15:0]      result,
  output logic                  flag_c,
  output logic                  flag_z,
  output logic                  flag_n,
  output logic                  flag_v
);
  import srso_pkg::*;

  logic [15:0] db;
  logic [15:0] raw;
  logic [16:0] sum;
  logic        msb_old;

  always_comb
  begin
    db      = byte_mode ? (dst & `SRSO_BYTE_MASK) : dst;
    msb_old = byte_mode ? db[7] : db[15];
    sum     = {1'b0, db} + (byte_mode ? `SRSO_SBC_ADD_B : `SRSO_SBC_ADD_W)
              + {16'h0000, carry_in};
    raw     = db;
    flag_c  = carry_in;
    flag_v  = 1'b0;
    case (op)
      SRSO_OP_SHL:
      begin
        raw    = {db[14:0], 1'b0};
        flag_c = msb_old;
        flag_v = byte_mode ?
          (db >= `SRSO_SHL_V_LO_B && db < `SRSO_SHL_V_HI_B) :
          (db >= `SRSO_SHL_V_LO_W && db < `SRSO_SHL_V_HI_W);
      end
      SRSO_OP_ROTL:
      begin
        raw    = {db[14:0], carry_in};
        flag_c = msb_old;
        flag_v = byte_mode ? (db[7] ^ db[6]) : (db[15] ^ db[14]);
      end
      SRSO_OP_SHR:
      begin
        raw    = byte_mode ? {8'h00, db[7], db[7:1]}
                           : {db[15], db[15:1]};
        flag_c = db[0];
      end
      SRSO_OP_ROTR:
      begin
        raw    = byte_mode ? {8'h00, carry_in, db[7:1]}
                           : {carry_in, db[15:1]};
        flag_c = db[0];
      end
      SRSO_OP_SBC:
      begin
        raw    = sum[15:0];
        flag_c = byte_mode ? sum[8] : sum[16];
        flag_v = msb_old & ~(byte_mode ? sum[7] : sum[15]);
      end
      default:
      begin
        raw    = db;
      end
    endcase
    result = byte_mode ? (raw & `SRSO_BYTE_MASK) : raw;
    flag_n = byte_mode ? result[7] : result[15];
    flag_z = (result == 16'h0000);
  end

endmodule
`default_nettype wire

// *** src/srso_top.sv ***
// stack save, returns, shifts and subtract-borrow with an avalon slave
// assumes a word-wide stack memory that answers a held request with ack
//
// Implementation choices: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "srso_map.svh"

// Behaviour
// - stack pointer steps two for any size
// - save lowers pointer by two, then writes
// - byte save writes low byte lane only
// - subroutine exit loads low pc, clears top
// - interrupt exit pops status and pc top
// - second pop gives low pc, pointer again
// - other operations keep the mode bits
// - left shift fills zero, top into carry
// - word left shift overflow window
// - byte left shift overflow window
// - left shift flags follow the result
// - left rotate carries through the carry
// - right shift keeps and copies sign
// - right rotate carries through the carry
// - subtract-borrow adds all-ones plus carry
// - subtract-borrow carry means no borrow
module srso_top
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic             mem_req,
  output logic             mem_we,
  output logic      [19:0] mem_addr,
  output logic      [15:0] mem_wdata,
  output logic      [1:0]  mem_be,
  input  wire logic [15:0] mem_rdata,
  input  wire logic        mem_ack,
  output logic             busy
);
  import srso_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  srso_state_t state;
  srso_op_t    cur_op;
  logic        cur_byte;
  logic [15:0] operand;
  logic [15:0] status_word;
  logic [19:0] program_counter;
  logic [19:0] stack_pointer;

  logic        take_wr;
  logic        load_rd;
  logic        start;
  srso_op_t    wr_op;
  logic        wr_byte;
  logic [31:0] wr_word;
  logic [15:0] alu_result;
  logic        alu_c;
  logic        alu_z;
  logic        alu_n;
  logic        alu_v;
  logic [19:0] sp_dec;
  logic [19:0] sp_inc;

  // ****************************************************************
  // avalon slave handshake
  // ****************************************************************
  // one wait cycle: waitrequest drops for exactly the taking edge
  assign take_wr = avs_write & ~avs_waitrequest;
  // read data latch on the waiting edge so they stand when taken
  assign load_rd = avs_read & avs_waitrequest;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      avs_waitrequest <= 1'b1;
    else
      avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
  end

  // byte lane merge over the old register value
  function automatic logic [31:0] merge
  (
    input logic [31:0] old,
    input logic [31:0] data,
    input logic [3:0]  be
  );
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
        m[i*8 +: 8] = data[i*8 +: 8];
    end
    return m;
  endfunction

  assign start   = take_wr && (avs_address == `SRSO_ADDR_CTRL) && !busy &&
                   avs_byteenable[0];
  assign wr_op   = srso_op_t'(avs_writedata[`SRSO_CTRL_OP_MSB:
                                            `SRSO_CTRL_OP_LSB]);
  assign wr_byte = avs_writedata[`SRSO_CTRL_BYTE];

  always_comb
  begin
    wr_word = 32'h00000000;
    case (avs_address)
      `SRSO_ADDR_OPERAND:
        wr_word = merge({16'h0000, operand}, avs_writedata, avs_byteenable);
      `SRSO_ADDR_STATUS:
        wr_word = merge({16'h0000, status_word}, avs_writedata,
                        avs_byteenable);
      `SRSO_ADDR_PC:
        wr_word = merge({12'h000, program_counter}, avs_writedata,
                        avs_byteenable);
      `SRSO_ADDR_SP:
        wr_word = merge({12'h000, stack_pointer}, avs_writedata,
                        avs_byteenable);
      default:
        wr_word = 32'h00000000;
    endcase
  end

  // ****************************************************************
  // read data
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      avs_readdata <= 32'h00000000;
    else if (load_rd)
    begin
      case (avs_address)
        `SRSO_ADDR_CTRL:
          avs_readdata <= {27'h0000000, cur_byte, 1'b0, cur_op};
        `SRSO_ADDR_OPERAND:
          avs_readdata <= {16'h0000, operand};
        `SRSO_ADDR_STATUS:
          avs_readdata <= {16'h0000, status_word};
        `SRSO_ADDR_PC:
          avs_readdata <= {12'h000, program_counter};
        `SRSO_ADDR_SP:
          avs_readdata <= {12'h000, stack_pointer};
        `SRSO_ADDR_BUSY:
          avs_readdata <= {31'h00000000, busy};
        default:
          avs_readdata <= 32'h00000000;
      endcase
    end
  end

  // ****************************************************************
  // datapath for shifts and subtract-borrow
  // ****************************************************************
  srso_alu u_alu
  (
    .byte_mode (wr_byte),
    .op        (wr_op),
    .dst       (operand),
    .carry_in  (status_word[`SRSO_SW_C]),
    .result    (alu_result),
    .flag_c    (alu_c),
    .flag_z    (alu_z),
    .flag_n    (alu_n),
    .flag_v    (alu_v)
  );

  assign sp_dec = stack_pointer - `SRSO_STACK_STEP;
  assign sp_inc = stack_pointer + `SRSO_STACK_STEP;

  // ****************************************************************
  // sequencer
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state    <= SRSO_ST_IDLE;
      cur_op   <= SRSO_OP_PUSH;
      cur_byte <= 1'b0;
      busy     <= 1'b0;
    end
    else
    begin
      case (state)
        SRSO_ST_IDLE:
        begin
          if (start)
          begin
            cur_op   <= wr_op;
            cur_byte <= wr_byte;
            case (wr_op)
              SRSO_OP_PUSH:
              begin
                state <= SRSO_ST_PUSH;
                busy  <= 1'b1;
              end
              SRSO_OP_SUBEX:
              begin
                state <= SRSO_ST_SUBEX;
                busy  <= 1'b1;
              end
              SRSO_OP_INTEX:
              begin
                state <= SRSO_ST_INT_SW;
                busy  <= 1'b1;
              end
              default:
              begin
                state <= SRSO_ST_IDLE;
              end
            endcase
          end
        end
        SRSO_ST_PUSH,
        SRSO_ST_SUBEX,
        SRSO_ST_INT_PC:
        begin
          if (mem_ack)
          begin
            state <= SRSO_ST_IDLE;
            busy  <= 1'b0;
          end
        end
        SRSO_ST_INT_SW:
        begin
          if (mem_ack)
            state <= SRSO_ST_INT_PC;
        end
        default:
        begin
          state <= SRSO_ST_IDLE;
          busy  <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************************************
  // memory request
  // ****************************************************************
  // the request is held until the ack edge, then dropped or reissued
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mem_req   <= 1'b0;
      mem_we    <= 1'b0;
      mem_addr  <= `SRSO_RST_SP;
      mem_wdata <= `SRSO_RST_WORD;
      mem_be    <= `SRSO_BE_WORD;
    end
    else if (state == SRSO_ST_IDLE)
    begin
      if (start && wr_op == SRSO_OP_PUSH)
      begin
        mem_req   <= 1'b1;
        mem_we    <= 1'b1;
        mem_addr  <= sp_dec;
        mem_wdata <= wr_byte ? (operand & `SRSO_BYTE_MASK) : operand;
        mem_be    <= wr_byte ? `SRSO_BE_LOW : `SRSO_BE_WORD;
      end
      else if (start && (wr_op == SRSO_OP_SUBEX ||
                         wr_op == SRSO_OP_INTEX))
      begin
        mem_req  <= 1'b1;
        mem_we   <= 1'b0;
        mem_addr <= stack_pointer;
        mem_be   <= `SRSO_BE_WORD;
      end
    end
    else if (mem_ack)
    begin
      if (state == SRSO_ST_INT_SW)
        mem_addr <= sp_inc;
      else
        mem_req <= 1'b0;
      mem_we <= 1'b0;
    end
  end

  // ****************************************************************
  // stack pointer
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      stack_pointer <= `SRSO_RST_SP;
    else if (state == SRSO_ST_IDLE && start && wr_op == SRSO_OP_PUSH)
      stack_pointer <= sp_dec;
    else if (state != SRSO_ST_IDLE && state != SRSO_ST_PUSH && mem_ack)
      stack_pointer <= sp_inc;
    else if (take_wr && avs_address == `SRSO_ADDR_SP && !busy)
      stack_pointer <= wr_word[19:0];
  end

  // ****************************************************************
  // program counter
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      program_counter <= `SRSO_RST_PC;
    else if (state == SRSO_ST_SUBEX && mem_ack)
      program_counter <= {`SRSO_PCHI_CLEAR, mem_rdata};
    else if (state == SRSO_ST_INT_SW && mem_ack)
      program_counter[19:16] <=
        mem_rdata[`SRSO_SW_PCHI_MSB:`SRSO_SW_PCHI_LSB];
    else if (state == SRSO_ST_INT_PC && mem_ack)
      program_counter[15:0] <= mem_rdata;
    else if (take_wr && avs_address == `SRSO_ADDR_PC && !busy)
      program_counter <= wr_word[19:0];
  end

  // ****************************************************************
  // status word
  // ****************************************************************
  // only the four flags move on datapath ops; mode bits stay put
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      status_word <= `SRSO_RST_SW;
    else if (state == SRSO_ST_INT_SW && mem_ack)
      status_word <= mem_rdata;
    else if (state == SRSO_ST_IDLE && start &&
             wr_op != SRSO_OP_PUSH && wr_op != SRSO_OP_SUBEX &&
             wr_op != SRSO_OP_INTEX)
    begin
      status_word[`SRSO_SW_C] <= alu_c;
      status_word[`SRSO_SW_Z] <= alu_z;
      status_word[`SRSO_SW_N] <= alu_n;
      status_word[`SRSO_SW_V] <= alu_v;
    end
    else if (take_wr && avs_address == `SRSO_ADDR_STATUS && !busy)
      status_word <= wr_word[15:0];
  end

  // ****************************************************************
  // operand, the shift destination
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      operand <= `SRSO_RST_WORD;
    else if (state == SRSO_ST_IDLE && start &&
             wr_op != SRSO_OP_PUSH && wr_op != SRSO_OP_SUBEX &&
             wr_op != SRSO_OP_INTEX)
      operand <= alu_result;
    else if (take_wr && avs_address == `SRSO_ADDR_OPERAND && !busy)
      operand <= wr_word[15:0];
  end

endmodule
`default_nettype wire

// *** verif/srso_monitor.sv ***
// concurrent checks on the bus and stack-memory ports of srso_top
// assumes it is bound to srso_top and sees only its ports
`timescale 1ns/1ps
`default_nettype none

module srso_monitor
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic        avs_waitrequest,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [19:0] mem_addr,
  input  wire logic [15:0] mem_wdata,
  input  wire logic [1:0]  mem_be,
  input  wire logic        mem_ack,
  input  wire logic        busy
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence bus_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence rd_done;
    mem_req && !mem_we && mem_ack;
  endsequence

  wait_answer_a: assert property (bus_req |=>
    !avs_waitrequest ##1 avs_waitrequest)
    else $error("waitrequest did not answer in one cycle");
  req_hold_a: assert property (mem_req && !mem_ack |=> mem_req &&
    $stable(mem_addr) && $stable(mem_wdata) &&
    $stable(mem_be) && $stable(mem_we))
    else $error("memory request changed before ack");
  busy_cover_a: assert property (mem_req |-> busy)
    else $error("memory request without busy");
  push_done_a: assert property (mem_req && mem_we && mem_ack |=>
    !mem_req && !busy)
    else $error("save did not finish at ack");
  byte_lane_a: assert property (mem_req && mem_we && mem_be != 2'h3 |->
    mem_be == 2'h1 && mem_wdata[15:8] == 8'h00)
    else $error("byte save lanes wrong");
  read_word_a: assert property (mem_req && !mem_we |-> mem_be == 2'h3)
    else $error("stack read not a whole word");
  pop_step_a: assert property (rd_done ##1 mem_req |->
    !mem_we && mem_addr == $past(mem_addr) + 20'h00002)
    else $error("second pop address not two above");
  even_addr_a: assert property (mem_req |-> !mem_addr[0])
    else $error("stack address odd");
  two_pops_a: assert property (rd_done ##1 mem_req |->
    ##[1:40] rd_done ##1 !mem_req)
    else $error("interrupt exit did not end after second pop");
  exit_idle_a: assert property (rd_done ##1 !mem_req |-> !busy)
    else $error("busy left high after last pop");
endmodule

`default_nettype wire

// *** verif/srso_stack_mem.sv ***
// word-wide stack memory model with a settable answer delay
// assumes requests are held until ack; lat sets the wait in cycles
`timescale 1ns/1ps
`default_nettype none

module srso_stack_mem
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [19:0] mem_addr,
  input  wire logic [15:0] mem_wdata,
  input  wire logic [1:0]  mem_be,
  input  wire logic [3:0]  lat,
  output logic      [15:0] mem_rdata,
  output logic             mem_ack
);
  logic [15:0] ram [256];
  logic [3:0]  cnt;
  wire  logic [7:0] idx;

  assign idx = mem_addr[8:1];

  // read data is only valid with ack; otherwise it toggles
  always @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      mem_ack   <= 1'b0;
      cnt       <= 4'h0;
      mem_rdata <= 16'h5AA5;
    end
    else if (mem_req && !mem_ack && cnt >= lat)
    begin
      mem_ack <= 1'b1;
      cnt     <= 4'h0;
      mem_rdata <= mem_we ? ~mem_rdata : ram[idx];
      if (mem_we && mem_be[0])
        ram[idx][7:0] <= mem_wdata[7:0];
      if (mem_we && mem_be[1])
        ram[idx][15:8] <= mem_wdata[15:8];
    end
    else
    begin
      mem_ack   <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack)
        cnt <= cnt + 4'h1;
    end
endmodule

`default_nettype wire

// *** verif/srso_top_test.sv ***
// self-checking bench for srso_top with a stack memory model
// assumes the register map header and package of the design
`timescale 1ns/1ps
`default_nettype none
`include "srso_map.svh"

module srso_top_test;
  import srso_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [4:0]  avs_address = 5'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hF;
  logic [31:0] avs_readdata, rd;
  logic        avs_waitrequest, mem_req, mem_we, mem_ack, busy;
  logic [19:0] mem_addr;
  logic [15:0] mem_wdata, mem_rdata;
  logic [1:0]  mem_be;
  logic [3:0]  lat = 4'h0;
  int          errors = 0;
  int          check_count = 0;
  int          cycles = 0;

  always #10 clk = ~clk;

  srso_top dut_u (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_be(mem_be),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack), .busy(busy));
  srso_stack_mem mem_u (.clk(clk), .rst_n(rst_n), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_be(mem_be), .lat(lat), .mem_rdata(mem_rdata), .mem_ack(mem_ack));

  // ********
  // bus and compare helpers
  // ********
  task automatic stop_test;
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      stop_test();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic reg_is(input logic [4:0] a, input logic [31:0] exp,
                        input string what);
    bus(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask

  task automatic start(input srso_op_t op, input logic byte_op);
    bus(1'b1, `SRSO_ADDR_CTRL, {27'h0, byte_op, 1'b0, op});
  endtask

  task automatic wait_idle;
    do @(posedge clk); while (busy !== 1'b0);
  endtask

  // ********
  // scenarios
  // ********
  task automatic t_push;
    lat <= 4'h6;
    mem_u.ram[8'h80] = 16'hBEEF;
    mem_u.ram[8'h81] = 16'hBEEF;
    bus(1'b1, `SRSO_ADDR_STATUS, 32'hF0F0);
    bus(1'b1, `SRSO_ADDR_SP, 32'h00104);
    bus(1'b1, `SRSO_ADDR_OPERAND, 32'h1234);
    start(SRSO_OP_PUSH, 1'b0);
    bus(1'b1, `SRSO_ADDR_SP, 32'h00000);
    reg_is(`SRSO_ADDR_BUSY, 32'h1, "busy flag");
    wait_idle();
    chk("word save", 32'h1234, {16'h0, mem_u.ram[8'h81]});
    reg_is(`SRSO_ADDR_SP, 32'h00102, "sp word save");
    bus(1'b1, `SRSO_ADDR_OPERAND, 32'hAB55);
    start(SRSO_OP_PUSH, 1'b1);
    wait_idle();
    chk("byte save", 32'hBE55, {16'h0, mem_u.ram[8'h80]});
    reg_is(`SRSO_ADDR_SP, 32'h00100, "sp byte save");
    reg_is(`SRSO_ADDR_STATUS, 32'hF0F0, "status save");
    $display("save test done");
  endtask

  task automatic t_ret;
    lat <= 4'h0;
    mem_u.ram[8'h80] = 16'h5678;
    bus(1'b1, `SRSO_ADDR_PC, 32'hABCDE);
    start(SRSO_OP_SUBEX, 1'b0);
    wait_idle();
    reg_is(`SRSO_ADDR_PC, 32'h05678, "pc sub exit");
    reg_is(`SRSO_ADDR_SP, 32'h00102, "sp sub exit");
    reg_is(`SRSO_ADDR_STATUS, 32'hF0F0, "status sub exit");
    $display("subroutine exit test done");
  endtask

  task automatic t_interrupt_exit_op;
    lat <= 4'h3;
    mem_u.ram[8'h80] = 16'h3107;
    mem_u.ram[8'h81] = 16'h9ABC;
    bus(1'b1, `SRSO_ADDR_SP, 32'h00100);
    start(SRSO_OP_INTEX, 1'b0);
    wait_idle();
    reg_is(`SRSO_ADDR_STATUS, 32'h3107, "status int exit");
    reg_is(`SRSO_ADDR_PC, 32'h39ABC, "pc int exit");
    reg_is(`SRSO_ADDR_SP, 32'h00104, "sp int exit");
    reg_is(5'h18, 32'h0, "unmapped read");
    $display("interrupt exit test done");
  endtask

  task automatic alu(input srso_op_t op, input logic b,
                     input logic [15:0] v, input logic c,
                     input logic [15:0] res, input logic [15:0] f);
    bus(1'b1, `SRSO_ADDR_STATUS, {16'h0, 16'hF1F6 | {15'h0, c}});
    bus(1'b1, `SRSO_ADDR_OPERAND, {16'h0, v});
    start(op, b);
    wait_idle();
    reg_is(`SRSO_ADDR_OPERAND, {16'h0, res}, "alu result");
    reg_is(`SRSO_ADDR_STATUS, {16'h0, 16'hF0F0 | f}, "alu status");
  endtask

  task automatic t_alu;
    alu(SRSO_OP_SHL, 1'b0, 16'h4000, 1'b0, 16'h8000, 16'h104);
    alu(SRSO_OP_SHL, 1'b0, 16'hC000, 1'b0, 16'h8000, 16'h005);
    alu(SRSO_OP_SHL, 1'b0, 16'h3FFF, 1'b1, 16'h7FFE, 16'h000);
    alu(SRSO_OP_SHL, 1'b1, 16'h0040, 1'b0, 16'h0080, 16'h104);
    alu(SRSO_OP_SHL, 1'b1, 16'h00C0, 1'b0, 16'h0080, 16'h005);
    alu(SRSO_OP_SHL, 1'b1, 16'hFF80, 1'b0, 16'h0000, 16'h103);
    alu(SRSO_OP_ROTL, 1'b0, 16'h8001, 1'b1, 16'h0003, 16'h101);
    alu(SRSO_OP_ROTL, 1'b1, 16'h00C1, 1'b0, 16'h0082, 16'h005);
    alu(SRSO_OP_SHR, 1'b0, 16'h8001, 1'b0, 16'hC000, 16'h005);
    alu(SRSO_OP_SHR, 1'b1, 16'h0081, 1'b0, 16'h00C0, 16'h005);
    alu(SRSO_OP_SHR, 1'b1, 16'h0001, 1'b1, 16'h0000, 16'h003);
    alu(SRSO_OP_ROTR, 1'b0, 16'h0001, 1'b1, 16'h8000, 16'h005);
    alu(SRSO_OP_ROTR, 1'b1, 16'h0002, 1'b1, 16'h0081, 16'h004);
    alu(SRSO_OP_SBC, 1'b0, 16'h0000, 1'b0, 16'hFFFF, 16'h004);
    alu(SRSO_OP_SBC, 1'b0, 16'h0005, 1'b1, 16'h0005, 16'h001);
    alu(SRSO_OP_SBC, 1'b0, 16'h8000, 1'b0, 16'h7FFF, 16'h101);
    alu(SRSO_OP_SBC, 1'b1, 16'h0000, 1'b1, 16'h0000, 16'h003);
    alu(SRSO_OP_SBC, 1'b1, 16'h0080, 1'b0, 16'h007F, 16'h101);
    reg_is(`SRSO_ADDR_CTRL, 32'h17, "last op code");
    $display("datapath test done");
  endtask

  initial
  begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_push();
    t_ret();
    t_interrupt_exit_op();
    t_alu();
    stop_test();
  end
endmodule

bind srso_top srso_monitor mon_u (.clk(clk), .rst_n(rst_n),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .mem_req(mem_req), .mem_we(mem_we),
  .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_be(mem_be),
  .mem_ack(mem_ack), .busy(busy));

`default_nettype wire
